// *** design/otpmc_host.sv ***
// Host controller that reads, programs, identifies and checks an OTP byte memory.
// Assumes the device pins are wired straight to pins_o/dq_i; the bench resolves the bus.
module otpmc_host
	import otpmc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire otpmc_pkg::otpmc_req_type req_i,
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic [7:0] dq_i,
	output otpmc_pkg::otpmc_pins_type pins_o,
	output logic [7:0] rdata_o,
	output logic done_o,
	output logic fail_o,
	output logic parity_ok_o,
	output logic [4:0] pulses_o
);
	otpmc_state_type state_reg;
	otpmc_req_type cur_reg;
	otpmc_pins_type pins_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [4:0] pulses_reg;
	logic [7:0] rdata_reg;
	logic [7:0] dq_s1_reg, dq_s2_reg, dq_s3_reg;
	logic done_reg, fail_reg, parity_reg;

	// Three-stage sampling; data must agree over two stages before use
	always_ff @(posedge clk_sys_i)
	begin
		dq_s1_reg <= dq_i;
		dq_s2_reg <= dq_s1_reg;
		dq_s3_reg <= dq_s2_reg;
	end

	assign req_ready_o = (state_reg == ST_IDLE);
	assign pins_o = pins_reg;
	assign rdata_o = rdata_reg;
	assign done_o = done_reg;
	assign fail_o = fail_reg;
	assign parity_ok_o = parity_reg;
	assign pulses_o = pulses_reg;

	function automatic logic bad_bits(input logic [7:0] got, input logic [7:0] want);
		bad_bits = (got != want);
	endfunction : bad_bits

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			state_reg <= ST_IDLE;
			cur_reg <= '0;
			pins_reg <= '{addr: 20'h00000, ce_n: 1'b1, oe_n: 1'b1, vpp_on: 1'b0, idv_on: 1'b0,
				dq_o: 8'hff, dq_oe: 1'b0};
			cnt_reg <= '0;
			pulses_reg <= 5'h00;
			rdata_reg <= 8'h00;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
			parity_reg <= 1'b0;
		end
		else
		begin
			done_reg <= 1'b0;
			case (state_reg)
				ST_IDLE:
				begin
					// Idle keeps the part in standby with no driver on the bus
					pins_reg.ce_n <= 1'b1;
					pins_reg.oe_n <= 1'b1;
					pins_reg.vpp_on <= 1'b0;
					pins_reg.idv_on <= 1'b0;
					pins_reg.dq_oe <= 1'b0;
					if (req_valid_i)
					begin
						cur_reg <= req_i;
						pulses_reg <= 5'h00;
						fail_reg <= 1'b0;
						cnt_reg <= '0;
						state_reg <= ST_SETUP;
						if (req_i.op == OP_IDENT)
						begin
							// Identify: only line 0 may be high, qualifier on the separate idv_on pin
							pins_reg.addr <= {19'h00000, req_i.addr[0]};
							pins_reg.idv_on <= 1'b1;
						end
						else if (req_i.op == OP_CHECK)
							pins_reg.addr <= 20'h00000;
						else
							pins_reg.addr <= req_i.addr;
						if (req_i.op == OP_PROG)
						begin
							// Byte and supply set up before the pulse
							pins_reg.dq_o <= req_i.data;
							pins_reg.dq_oe <= 1'b1;
							pins_reg.vpp_on <= 1'b1;
						end
					end
				end
				ST_SETUP:
				begin
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == CNT_W'(SETUP_CYC - 1))
					begin
						cnt_reg <= '0;
						pins_reg.ce_n <= 1'b0; // Chip select driven low once setup has elapsed
						if (cur_reg.op == OP_PROG)
						begin
							pulses_reg <= pulses_reg + 5'h01;
							state_reg <= ST_PULSE;
						end
						else
						begin
							pins_reg.oe_n <= 1'b0;
							state_reg <= ST_SAMPLE;
						end
					end
				end
				ST_PULSE:
				begin
					// Address and data frozen for the whole pulse
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == CNT_W'(PULSE_CYC - 1))
					begin
						cnt_reg <= '0;
						pins_reg.ce_n <= 1'b1; // High select ends the write
						state_reg <= ST_RECOV;
					end
				end
				ST_RECOV:
				begin
					// Supply off and bus released before the verify read
					cnt_reg <= cnt_reg + 1'b1;
					pins_reg.vpp_on <= 1'b0;
					pins_reg.dq_oe <= 1'b0;
					if (cnt_reg == CNT_W'(SETUP_CYC - 1))
					begin
						cnt_reg <= '0;
						pins_reg.ce_n <= 1'b0;
						pins_reg.oe_n <= 1'b0;
						state_reg <= ST_SAMPLE;
					end
				end
				ST_SAMPLE:
				begin
					// Sample past the verify delay plus synchroniser depth
					cnt_reg <= cnt_reg + 1'b1;
					// Late agreement still samples; no wait for a counter wrap
					if (cnt_reg >= CNT_W'(VERIFY_CYC + 3) && dq_s2_reg == dq_s3_reg)
					begin
						cnt_reg <= '0;
						rdata_reg <= dq_s3_reg;
						parity_reg <= ^dq_s3_reg; // Identifier odd parity, msb carries it
						pins_reg.ce_n <= 1'b1;
						pins_reg.oe_n <= 1'b1;
						state_reg <= ST_DONE;
						if (cur_reg.op == OP_PROG && bad_bits(dq_s3_reg, cur_reg.data))
						begin
							// Retry until match or the pulse budget is spent
							if (pulses_reg < MAX_PULSES_5)
							begin
								pins_reg.dq_oe <= 1'b1;
								pins_reg.vpp_on <= 1'b1;
								state_reg <= ST_SETUP;
							end
							else
								fail_reg <= 1'b1;
						end
						else if (cur_reg.op == OP_CHECK)
						begin
							// Readback from address 0: requested byte expected, scan stops at first mismatch or ADDR_LAST
							if (bad_bits(dq_s3_reg, cur_reg.data))
								fail_reg <= 1'b1;
							if (pins_reg.addr != ADDR_LAST && !bad_bits(dq_s3_reg, cur_reg.data))
								state_reg <= ST_SCAN;
						end
					end
				end
				ST_SCAN:
				begin
					pins_reg.addr <= pins_reg.addr + 20'h00001;
					state_reg <= ST_SETUP;
				end
				ST_DONE:
				begin
					done_reg <= 1'b1;
					pins_reg.idv_on <= 1'b0;
					state_reg <= ST_IDLE;
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// Never drive the data lines while the part may drive them
	chk_no_contention: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		!(pins_o.dq_oe && !pins_o.oe_n))
		else $error("data bus driven while output gate low");
	// Supply, driven data and low select all present throughout a pulse
	chk_pulse_supply: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(state_reg == ST_PULSE) |-> (pins_o.vpp_on && pins_o.dq_oe && !pins_o.ce_n))
		else $error("pulse without supply or data");
	// Address and data stable through the pulse
	chk_pulse_stable: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(state_reg == ST_PULSE && $past(state_reg) == ST_PULSE) |-> $stable(pins_o.addr) && $stable(pins_o.dq_o))
		else $error("address or data moved during pulse");
	// Pulse count bounded
	chk_pulse_budget: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		pulses_reg <= MAX_PULSES_5)
		else $error("too many program pulses");
	// Identify keeps every other address line low
	chk_ident_addr: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		pins_o.idv_on |-> (pins_o.addr[19:1] == 19'h00000))
		else $error("identify with stray address bits");
	// Idle means standby
	chk_idle_standby: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(state_reg == ST_IDLE && $past(state_reg) == ST_IDLE) |-> (pins_o.ce_n && pins_o.oe_n && !pins_o.dq_oe))
		else $error("idle without standby");
	// Pulse ends with select high
	chk_pulse_end: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(state_reg == ST_PULSE ##1 state_reg == ST_RECOV) |-> pins_o.ce_n)
		else $error("select still low after pulse");
	// Sampling only with select and gate low and supply off
	chk_verify_select: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(state_reg == ST_SAMPLE) |-> (!pins_o.ce_n && !pins_o.oe_n && !pins_o.vpp_on))
		else $error("sample without select and gate");
endmodule : otpmc_host

// *** design/otpmc_pkg.sv ***
// Package for the OTP memory host controller: pin widths, timing counts, types.
// Assumes a 10 MHz system clock and a device reached through its parallel pins.
package otpmc_pkg;
	localparam int unsigned ADDR_W = 20;
	localparam int unsigned DATA_W = 8;
	localparam logic [19:0] ADDR_LAST = 20'hfffff;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam int unsigned IDSEL_BIT = 9;
	localparam int unsigned CLK_NS = 100;
	localparam int unsigned PULSE_US = 50;
	localparam int unsigned PULSE_CYC = (PULSE_US * 1000) / CLK_NS;
	localparam int unsigned SETUP_US = 2;
	localparam int unsigned SETUP_CYC = (SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int unsigned VERIFY_NS = 150;
	localparam int unsigned VERIFY_CYC = (VERIFY_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned MAX_PULSES = 25;
	localparam logic [4:0] MAX_PULSES_5 = 5'h19;
	localparam int unsigned CNT_W = 10;
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_PROG = 2'h1;
	localparam logic [1:0] OP_IDENT = 2'h2;
	localparam logic [1:0] OP_CHECK = 2'h3;

	typedef struct packed
	{
		logic [19:0] addr;
		logic [7:0] data;
		logic [1:0] op;
	} otpmc_req_type;

	typedef struct packed
	{
		logic [19:0] addr;
		logic ce_n;
		logic oe_n;
		logic vpp_on;
		logic idv_on;
		logic [7:0] dq_o;
		logic dq_oe;
	} otpmc_pins_type;

	typedef enum logic [6:0]
	{
		ST_IDLE = 7'h01,
		ST_SETUP = 7'h02,
		ST_PULSE = 7'h04,
		ST_RECOV = 7'h08,
		ST_SAMPLE = 7'h10,
		ST_DONE = 7'h20,
		ST_SCAN = 7'h40
	} otpmc_state_type;
endpackage : otpmc_pkg

// *** sim/otpmc_dev_model.sv ***
// Behavioural OTP byte memory standing on the far side of the host controller.
// Assumes the bench resolves the shared data lines from both enables.
module otpmc_dev_model
	import otpmc_pkg::*;
#(
	parameter logic [7:0] MAKER_ID = 8'h8a, // Arbitrary value, odd parity
	parameter logic [7:0] DEVICE_ID = 8'h07 // Arbitrary value, odd parity
)
(
	input wire otpmc_pkg::otpmc_pins_type pins_i,
	input wire logic [7:0] dq_i,
	input wire logic stuck_i,
	output logic [7:0] q_o,
	output logic q_oe_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Full store filled erased at start; plain arrays suit every simulator
	logic [7:0] mem [0:(1 << ADDR_W) - 1];
	logic [7:0] cur;

	initial
	begin
		for (int k = 0; k < (1 << ADDR_W); k++)
			mem[k] = ERASED_BYTE;
	end

	// Stuck cells let a scenario force the give-up path
	always @(negedge pins_i.ce_n)
	begin
		if (pins_i.vpp_on && !stuck_i)
		begin
			cur = mem[pins_i.addr];
			mem[pins_i.addr] = cur & dq_i;
		end
	end

	// Continuous reads follow array writes without a wide sensitivity list
	assign q_oe_o = !pins_i.ce_n && !pins_i.oe_n && !pins_i.vpp_on;
	assign q_o = pins_i.idv_on ? (pins_i.addr[0] ? DEVICE_ID : MAKER_ID)
		: mem[pins_i.addr];
endmodule : otpmc_dev_model

// *** sim/testbench.sv ***
// Self-checking bench for the OTP host controller against a device model.
// Assumes a 10 MHz clock and the pin and request types of the package.
module testbench;
	import otpmc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys;
	logic nrst;
	logic req_valid;
	logic req_ready;
	logic stuck;
	logic dev_oe;
	logic done;
	logic fail;
	logic parity_ok;
	logic [4:0] pulses;
	logic [7:0] dq;
	logic [7:0] dev_q;
	logic [7:0] rdata;
	logic [7:0] float_pat = 8'h55;
	otpmc_req_type req;
	otpmc_pins_type pins;
	int n_mismatch = 0;
	int n_tests = 0;

	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// Released lines wander, so a stale byte never passes
	always @(posedge clk_sys) float_pat <= ~float_pat;
	assign dq = pins.dq_oe ? pins.dq_o : (dev_oe ? dev_q : float_pat);

	otpmc_host i_dut (.clk_sys_i(clk_sys), .nrst_i(nrst), .req_i(req), .req_valid_i(req_valid),
		.req_ready_o(req_ready), .dq_i(dq), .pins_o(pins), .rdata_o(rdata), .done_o(done),
		.fail_o(fail), .parity_ok_o(parity_ok), .pulses_o(pulses));
	otpmc_dev_model i_dev (.pins_i(pins), .dq_i(dq), .stuck_i(stuck), .q_o(dev_q), .q_oe_o(dev_oe));

	task finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test

	task cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task run_op(input logic [1:0] op, input logic [19:0] a, input logic [7:0] d);
		int i;
		req <= '{addr: a, data: d, op: op};
		req_valid <= 1'b1;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		i = 0;
		while (done !== 1'b1 && i < 20000)
		begin
			@(posedge clk_sys);
			i++;
		end
		if (i == 20000)
		begin
			n_mismatch++;
			finish_test();
		end
	endtask : run_op

	task t_idle_pins;
		cmp("ce_n", 8'h01, {7'h00, pins.ce_n});
		cmp("vpp_on", 8'h00, {7'h00, pins.vpp_on});
		cmp("dq_oe", 8'h00, {7'h00, pins.dq_oe});
		cmp("req_ready", 8'h01, {7'h00, req_ready});
	endtask : t_idle_pins

	task t_program_read;
		run_op(OP_READ, ADDR_LAST, 8'h00);
		cmp("blank byte", ERASED_BYTE, rdata);
		run_op(OP_PROG, 20'h00005, 8'h5a);
		cmp("program fail", 8'h00, {7'h00, fail});
		cmp("pulses", 8'h01, {3'h0, pulses});
		run_op(OP_READ, 20'h00005, 8'h00);
		cmp("read back", 8'h5a, rdata);
	endtask : t_program_read

	task t_identify;
		run_op(OP_IDENT, 20'h00000, 8'h00);
		cmp("maker id", i_dev.MAKER_ID, rdata);
		cmp("maker parity", 8'h01, {7'h00, parity_ok});
		run_op(OP_IDENT, 20'h00001, 8'h00);
		cmp("device id", i_dev.DEVICE_ID, rdata);
		cmp("device parity", 8'h01, {7'h00, parity_ok});
	endtask : t_identify

	task t_give_up;
		stuck <= 1'b1;
		run_op(OP_PROG, 20'h00006, 8'h00);
		stuck <= 1'b0;
		cmp("give-up fail", 8'h01, {7'h00, fail});
		cmp("give-up pulses", {3'h0, MAX_PULSES_5}, {3'h0, pulses});
	endtask : t_give_up

	task t_check_array;
		run_op(OP_PROG, 20'h00000, 8'h00);
		run_op(OP_CHECK, 20'h00000, 8'h00);
		cmp("check fail", 8'h01, {7'h00, fail});
		cmp("check byte", ERASED_BYTE, rdata);
		cmp("check stop", 8'h01, pins.addr[7:0]);
	endtask : t_check_array

	initial
	begin
		nrst = 1'b0;
		req_valid = 1'b0;
		stuck = 1'b0;
		req = '0;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		t_idle_pins();
		t_program_read();
		t_identify();
		t_give_up();
		t_check_array();
		finish_test();
	end
endmodule : testbench
